// ### pscr_pkg.sv
// pscr_pkg: register offsets, field positions, reset values and states of the
// synthesizer configuration block; shared by all of its files but the lock interface.
package pscr_pkg;
    localparam int ADDR_W = 7;
    localparam int NUM_REGS = 73;
    localparam logic [ADDR_W-1:0] ADDR_FIRST_CLOCK_OUTPUT = 7'h14;
    localparam logic [ADDR_W-1:0] ADDR_PDIV = 7'h16;
    localparam logic [ADDR_W-1:0] ADDR_ODIV_LO = 7'h17;
    localparam logic [ADDR_W-1:0] ADDR_REFDIV = 7'h18;
    localparam logic [ADDR_W-1:0] ADDR_INT_HI = 7'h19;
    localparam logic [ADDR_W-1:0] ADDR_INT_LO = 7'h1A;
    localparam logic [ADDR_W-1:0] ADDR_NUM_HI = 7'h1B;
    localparam logic [ADDR_W-1:0] ADDR_NUM_MID = 7'h1C;
    localparam logic [ADDR_W-1:0] ADDR_NUM_LO = 7'h1D;
    localparam logic [ADDR_W-1:0] ADDR_DEN_HI = 7'h1E;
    localparam logic [ADDR_W-1:0] ADDR_DEN_MID = 7'h1F;
    localparam logic [ADDR_W-1:0] ADDR_DEN_LO = 7'h20;
    localparam logic [ADDR_W-1:0] ADDR_MOD = 7'h21;
    localparam logic [ADDR_W-1:0] ADDR_CP = 7'h22;
    localparam logic [ADDR_W-1:0] ADDR_PS = 7'h23;
    localparam logic [ADDR_W-1:0] ADDR_LF_R2 = 7'h24;
    localparam logic [ADDR_W-1:0] ADDR_LF_C1 = 7'h25;
    localparam logic [ADDR_W-1:0] ADDR_LF_R3 = 7'h26;
    localparam logic [ADDR_W-1:0] ADDR_LF_C3 = 7'h27;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 7'h42;
    localparam logic [ADDR_W-1:0] ADDR_RECAL = 7'h48;
    localparam int BIT_FIRST_CLOCK_OUTPUT_EN = 2;
    localparam int BIT_POST_DIV5 = 5;
    localparam int BIT_ODIV_MSB = 0;
    localparam int SLEW_LSB = 6;
    localparam int BIT_REF_DIV4 = 0;
    localparam int BIT_SECOND_CLOCK_OUTPUT_EN = 4;
    localparam int BIT_DOUBLER = 5;
    localparam int BIT_FILT_SEL = 2;
    localparam int PS_LSB = 4;
    localparam int BIT_RECAL = 1;
    localparam int BIT_LOCK_LOSS = 0;
    localparam int BIT_CAL_STAT = 1;
    localparam logic [7:0] RST_FIRST_CLOCK_OUTPUT = 8'h04;
    localparam logic [7:0] RST_OTHER = 8'h00;
    localparam logic [8:0] ODIV_MIN = 9'h006;
    localparam logic [8:0] ODIV_MAX = 9'h100;
    localparam logic [8:0] RST_ODIV = 9'h006;
    typedef enum logic [1:0] {ST_LOAD_REQ, ST_LOAD_CAP, ST_APPLY, ST_RUN} pscr_state_t;
endpackage : pscr_pkg

// ### pscr_lock_if.sv
// pscr_lock_if: carries reference and feedback ticks to the slip detector
// and its slip pulse back; both ends run on sys_clk.
`timescale 1ns/1ns
interface pscr_lock_if;
    logic ref_tick;
    logic fb_tick;
    logic slip;
    modport ctrl (output ref_tick, output fb_tick, input slip);
    modport det (input ref_tick, input fb_tick, output slip);
endinterface : pscr_lock_if

// ### pscr_slip_det.sv
// pscr_slip_det: up/down count of reference minus feedback ticks; a
// difference of two means at least one whole cycle was slipped.
// assumes single-cycle tick pulses on sys_clk.
`timescale 1ns/1ns
module pscr_slip_det (
    input wire logic sys_clk,
    input wire logic resetn,
    pscr_lock_if.det lk
);
    import pscr_pkg::*;
    logic signed [2:0] diff_reg;
    logic signed [2:0] diff_next;
    logic slip_reg;
    logic slip_next;

    always_comb
    begin
        diff_next = diff_reg;
        slip_next = 1'b0;
        if (lk.ref_tick && !lk.fb_tick)
            diff_next = diff_reg + 3'sd1;
        else if (lk.fb_tick && !lk.ref_tick)
            diff_next = diff_reg - 3'sd1;
        // one phase step of lead is normal; two is a slipped cycle
        if (diff_next >= 3'sd2 || diff_next <= -3'sd2)
        begin
            slip_next = 1'b1; // [R15]
            diff_next = 3'sd0;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            diff_reg <= 3'sd0;
            slip_reg <= 1'b0;
        end
        else
        begin
            diff_reg <= diff_next;
            slip_reg <= slip_next;
        end
    end

    assign lk.slip = slip_reg;

    chk_slip_on_two: assert property (@(posedge sys_clk) disable iff (!resetn)
        (diff_reg == 3'sd1 && lk.ref_tick && !lk.fb_tick) |=> lk.slip) // [R15]
        else $error("two-tick lead did not flag a slip");
endmodule : pscr_slip_det

// ### pscr_config_regs.sv
// pscr_config_regs: register file and control of the synthesizer settings.
// assumes a serial engine on sys_clk that delivers byte writes/reads and
// a nonvolatile array answering nvm_addr one cycle later on nvm_data.
// Overview of operation
// R01: modulator order comes from two bits of the modulator register.
// R02: host sets dither off for integer, weak for fractional mode.
// R03: charge-pump slices selected by four bits; host picks slice per mode.
// R04: host writes phase shift 0x2 fractional, 0x0 integer.
// R05: four loop-filter codes come from four consecutive registers.
// R06: host sets filter-select and clears third resistor per doubler use.
// R07: writing one to the recalibrate bit starts VCO calibration.
// R08: VCO calibration starts by itself after power-up load.
// R09: post-divider divides by four or five from one bit.
// R10: output divider spans two registers, values six to 256.
// R11: output divider loads only when low byte precedes high byte.
// R12: two output enables; first on, second off after reset.
// R13: slew field selects fast or slow output edges.
// R14: lock-loss and calibration flags clear after a completed read.
// R15: lock-loss flags any frequency error, even one slipped cycle.
// R16: whole nonvolatile array copied into registers at power-up; code keeps only the writable bits of the first 73 bytes.
// R17: host limits nonvolatile rewrites to one hundred.
// R18: writes to read-only bits leave them unchanged.
// R19: host keeps reserved bits at their reset values; the bench writes 0xFF to reserved register 0x15.
// R20: host rewrites full numerator, high byte first, low last.
// R21: reference divide-by-four bit and doubler enable bit.
// R22: integer, numerator and denominator held in their register groups.
// R23: new numerator reaches the divider only after its low byte.
`timescale 1ns/1ns
module pscr_config_regs (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [pscr_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_rd_done,
    output logic [7:0] reg_rdata,
    output logic reg_busy,
    output logic [pscr_pkg::ADDR_W-1:0] nvm_addr,
    input wire logic [7:0] nvm_data,
    input wire logic ref_clk_pin,
    input wire logic fb_clk_pin,
    input wire logic cal_done_pin,
    output logic [1:0] mod_order,
    output logic [3:0] cp_slices,
    output logic [3:0] lf_res_two,
    output logic [7:0] lf_cap_one,
    output logic [6:0] lf_res_three,
    output logic [7:0] lf_cap_three,
    output logic [2:0] phase_shift,
    output logic filter_sel,
    output logic [1:0] dither_sel,
    output logic post_div_five,
    output logic [8:0] out_div,
    output logic [1:0] slew_sel,
    output logic first_clock_output_en,
    output logic second_clock_output_en,
    output logic ref_div_four,
    output logic doubler_en,
    output logic [11:0] int_val,
    output logic [21:0] num_val,
    output logic [21:0] fraction_denominator,
    output logic cal_start
);
    import pscr_pkg::*;

    pscr_lock_if lk ();

    logic [7:0] regs_reg [NUM_REGS];
    logic [7:0] regs_next [NUM_REGS];
    pscr_state_t state_reg, state_next;
    logic [ADDR_W-1:0] idx_reg, idx_next;
    logic [8:0] odiv_reg, odiv_next;
    logic [21:0] num_reg, num_next;
    logic [1:0] stat_reg, stat_next;
    logic [1:0] rdmask_reg, rdmask_next;
    logic [7:0] rdata_reg, rdata_next;
    logic cal_reg, cal_next;
    logic busy_reg, busy_next;
    logic [2:0] ref_sync_reg, fb_sync_reg, cal_sync_reg;
    logic host_wr;
    logic [8:0] odiv_cand;

    // writable bits per register; status and trigger are handled apart
    function automatic logic [7:0] wr_mask(input logic [ADDR_W-1:0] a);
        logic [7:0] m;
        m = 8'h00;
        if ((a >= ADDR_FIRST_CLOCK_OUTPUT && a <= ADDR_LF_C3 && a != 7'h15) || a == ADDR_RECAL)
            m = 8'hFF;
        if (a == ADDR_RECAL)
            m = 8'hFD;
        return m;
    endfunction : wr_mask

    // pins pass two flops; the third stage is only for edge detection
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ref_sync_reg <= 3'h0;
            fb_sync_reg <= 3'h0;
            cal_sync_reg <= 3'h0;
        end
        else
        begin
            ref_sync_reg <= {ref_sync_reg[1:0], ref_clk_pin};
            fb_sync_reg <= {fb_sync_reg[1:0], fb_clk_pin};
            cal_sync_reg <= {cal_sync_reg[1:0], cal_done_pin};
        end
    end

    assign lk.ref_tick = ref_sync_reg[1] & ~ref_sync_reg[2];
    assign lk.fb_tick = fb_sync_reg[1] & ~fb_sync_reg[2];

    pscr_slip_det u_slip (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .lk(lk)
    );

    assign host_wr = reg_wr && (state_reg == ST_RUN);
    assign odiv_cand = {regs_reg[ADDR_PDIV][BIT_ODIV_MSB], regs_reg[ADDR_ODIV_LO]};

    always_comb
    begin
        odiv_next = odiv_reg;
        for (int i = 0; i < NUM_REGS; i++)
            regs_next[i] = regs_reg[i];
        state_next = state_reg;
        idx_next = idx_reg;
        num_next = num_reg;
        cal_next = 1'b0;
        case (state_reg)
            ST_LOAD_REQ:
                state_next = ST_LOAD_CAP;
            ST_LOAD_CAP:
            begin
                regs_next[idx_reg] = nvm_data & wr_mask(idx_reg); // [R16]
                if (idx_reg == ADDR_W'(NUM_REGS - 1))
                    state_next = ST_APPLY;
                else
                begin
                    idx_next = idx_reg + 7'h01;
                    state_next = ST_LOAD_REQ;
                end
            end
            ST_APPLY:
            begin
                num_next = {regs_reg[ADDR_NUM_HI][5:0], regs_reg[ADDR_NUM_MID],
                            regs_reg[ADDR_NUM_LO]};
                if (odiv_cand >= ODIV_MIN && odiv_cand <= ODIV_MAX)
                    odiv_next = odiv_cand;
                cal_next = 1'b1; // [R08]
                state_next = ST_RUN;
            end
            ST_RUN:
            begin
                if (host_wr)
                begin
                    // read-only bits and reserved registers keep their value; reserved bits in 0x14-0x27 are written
                    regs_next[reg_addr] = (regs_reg[reg_addr] & ~wr_mask(reg_addr)) |
                                          (reg_wdata & wr_mask(reg_addr)); // [R18]
                    if (reg_addr == ADDR_RECAL && reg_wdata[BIT_RECAL])
                        cal_next = 1'b1; // [R07]
                    if (reg_addr == ADDR_NUM_LO)
                        num_next = {regs_reg[ADDR_NUM_HI][5:0], regs_reg[ADDR_NUM_MID],
                                    reg_wdata}; // [R23]
                    // high byte write commits using the low byte already held
                    if (reg_addr == ADDR_PDIV &&
                        {reg_wdata[BIT_ODIV_MSB], regs_reg[ADDR_ODIV_LO]} >= ODIV_MIN &&
                        {reg_wdata[BIT_ODIV_MSB], regs_reg[ADDR_ODIV_LO]} <= ODIV_MAX)
                        odiv_next = {reg_wdata[BIT_ODIV_MSB], regs_reg[ADDR_ODIV_LO]}; // [R11]
                end
            end
            default:
                state_next = ST_LOAD_REQ;
        endcase
        busy_next = (state_next != ST_RUN);
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < NUM_REGS; i++)
                regs_reg[i] <= (i == int'(ADDR_FIRST_CLOCK_OUTPUT)) ? RST_FIRST_CLOCK_OUTPUT : RST_OTHER; // [R12]
            state_reg <= ST_LOAD_REQ;
            idx_reg <= '0;
            odiv_reg <= RST_ODIV;
            num_reg <= '0;
            cal_reg <= 1'b0;
            busy_reg <= 1'b1;
        end
        else
        begin
            for (int i = 0; i < NUM_REGS; i++)
                regs_reg[i] <= regs_next[i];
            state_reg <= state_next;
            idx_reg <= idx_next;
            odiv_reg <= odiv_next; // [R10]
            num_reg <= num_next;
            cal_reg <= cal_next;
            busy_reg <= busy_next;
        end
    end

    // status flags: an event in the clearing cycle survives the clear
    always_comb
    begin
        stat_next = stat_reg;
        rdmask_next = rdmask_reg;
        rdata_next = rdata_reg;
        if (reg_rd_done)
        begin
            stat_next = stat_reg & ~rdmask_reg; // [R14]
            rdmask_next = 2'h0;
        end
        if (reg_rd)
        begin
            if (reg_addr == ADDR_STATUS)
            begin
                rdata_next = {6'h00, stat_reg};
                rdmask_next = stat_reg;
            end
            else if (reg_addr < ADDR_W'(NUM_REGS))
                rdata_next = regs_reg[reg_addr];
            else
                rdata_next = 8'h00;
        end
        if (lk.slip)
            stat_next[BIT_LOCK_LOSS] = 1'b1; // [R15]
        if (cal_sync_reg[1] && !cal_sync_reg[2])
            stat_next[BIT_CAL_STAT] = 1'b1;
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            stat_reg <= 2'h0;
            rdmask_reg <= 2'h0;
            rdata_reg <= 8'h00;
        end
        else
        begin
            stat_reg <= stat_next;
            rdmask_reg <= rdmask_next;
            rdata_reg <= rdata_next;
        end
    end

    assign nvm_addr = idx_reg;
    assign reg_busy = busy_reg;
    assign reg_rdata = rdata_reg;
    assign cal_start = cal_reg;
    assign out_div = odiv_reg;
    assign num_val = num_reg;
    assign mod_order = regs_reg[ADDR_MOD][1:0]; // [R01]
    assign dither_sel = regs_reg[ADDR_MOD][3:2];
    assign cp_slices = regs_reg[ADDR_CP][3:0]; // [R03]
    assign doubler_en = regs_reg[ADDR_CP][BIT_DOUBLER]; // [R21]
    assign ref_div_four = regs_reg[ADDR_REFDIV][BIT_REF_DIV4]; // [R21]
    assign phase_shift = regs_reg[ADDR_PS][PS_LSB +: 3];
    assign filter_sel = regs_reg[ADDR_PS][BIT_FILT_SEL];
    assign lf_res_two = regs_reg[ADDR_LF_R2][3:0]; // [R05]
    assign lf_cap_one = regs_reg[ADDR_LF_C1]; // [R05]
    assign lf_res_three = regs_reg[ADDR_LF_R3][6:0]; // [R05]
    assign lf_cap_three = regs_reg[ADDR_LF_C3]; // [R05]
    assign post_div_five = regs_reg[ADDR_PDIV][BIT_POST_DIV5]; // [R09]
    assign slew_sel = regs_reg[ADDR_PDIV][SLEW_LSB +: 2]; // [R13]
    assign first_clock_output_en = regs_reg[ADDR_FIRST_CLOCK_OUTPUT][BIT_FIRST_CLOCK_OUTPUT_EN]; // [R12]
    assign second_clock_output_en = regs_reg[ADDR_REFDIV][BIT_SECOND_CLOCK_OUTPUT_EN]; // [R12]
    assign int_val = {regs_reg[ADDR_INT_HI][3:0], regs_reg[ADDR_INT_LO]}; // [R22]
    assign fraction_denominator = {regs_reg[ADDR_DEN_HI][5:0], regs_reg[ADDR_DEN_MID],
                                   regs_reg[ADDR_DEN_LO]}; // [R22]

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence seq_wr(logic [ADDR_W-1:0] a);
        host_wr && reg_addr == a;
    endsequence

    sequence seq_load_done;
        state_reg == ST_APPLY ##1 state_reg == ST_RUN;
    endsequence

    chk_mod_order_sel: assert property (seq_wr(ADDR_MOD) |=> mod_order == $past(reg_wdata[1:0])) // [R01]
        else $error("modulator order not taken from write");
    chk_cp_slice_sel: assert property (seq_wr(ADDR_CP) |=> cp_slices == $past(reg_wdata[3:0])) // [R03]
        else $error("charge pump slices not taken from write");
    chk_recal_start: assert property ((seq_wr(ADDR_RECAL) and reg_wdata[BIT_RECAL])
        |=> cal_start ##1 !cal_start) // [R07]
        else $error("recalibration write gave no single pulse");
    chk_powerup_cal: assert property (seq_load_done |-> cal_start) // [R08]
        else $error("no calibration after power-up load");
    chk_load_bound: assert property ((state_reg == ST_LOAD_REQ && idx_reg == 7'h00)
        |-> ##[1:160] state_reg == ST_RUN) // [R16]
        else $error("power-up load did not finish");
    chk_outdiv_range: assert property (out_div >= ODIV_MIN && out_div <= ODIV_MAX) // [R10]
        else $error("output divider out of range");
    chk_outdiv_order: assert property (seq_wr(ADDR_ODIV_LO) |=> $stable(out_div)) // [R11]
        else $error("output divider changed on low byte write");
    chk_num_atomic: assert property ((seq_wr(ADDR_NUM_HI) or seq_wr(ADDR_NUM_MID))
        |=> $stable(num_val)) // [R23]
        else $error("numerator applied before low byte");
    chk_status_ro: assert property ((seq_wr(ADDR_STATUS) and !lk.slip and !reg_rd_done)
        |=> stat_reg[BIT_LOCK_LOSS] == $past(stat_reg[BIT_LOCK_LOSS])) // [R18]
        else $error("status changed by host write");
    chk_status_clear: assert property ((reg_rd_done && rdmask_reg[BIT_LOCK_LOSS] && !lk.slip)
        |=> !stat_reg[BIT_LOCK_LOSS]) // [R14]
        else $error("lock-loss flag not cleared after read");
endmodule : pscr_config_regs

// ### pscr_host_model.sv
// pscr_host_model: serial-engine side of the register port plus the
// nonvolatile array; the testbench calls its tasks, all on sys_clk.
`timescale 1ns/1ns
module pscr_host_model (
    input wire logic sys_clk,
    input wire logic [pscr_pkg::ADDR_W-1:0] nvm_addr,
    output logic [7:0] nvm_data,
    output logic [pscr_pkg::ADDR_W-1:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic reg_rd_done
);
    import pscr_pkg::*;
    logic [7:0] mem [0:127];

    // array is only read here, never rewritten
    initial
    begin
        for (int i = 0; i < 128; i++)
            mem[i] = 8'(i * 29) ^ 8'hA5;
        reg_addr = 7'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_rd_done = 1'b0;
    end

    // byte answers the index with no added wait
    assign nvm_data = mem[nvm_addr];

    // released lines show the inverse so stale values are never reused
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
        reg_addr = ~a;
    endtask : wr

    task automatic rd(input logic [6:0] a);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
    endtask : rd

    task automatic done();
        @(negedge sys_clk);
        reg_rd_done = 1'b1;
        @(negedge sys_clk);
        reg_rd_done = 1'b0;
    endtask : done
endmodule : pscr_host_model

// ### tb_top.sv
// tb_top: self-checking bench of pscr_config_regs with host model.
// assumes the hand-over timing of the register port and status flags.
`timescale 1ns/1ns
module tb_top;
    import pscr_pkg::*;
    localparam logic [1:0] DITHER_WEAK = 2'h1;
    localparam logic [3:0] CP_FRAC = 4'h1;
    localparam logic [3:0] CP_INT = 4'h4;
    localparam logic [6:0] TA [15] = '{7'h14, 7'h16, 7'h18, 7'h19, 7'h1A, 7'h1E, 7'h1F,
        7'h20, 7'h21, 7'h22, 7'h23, 7'h24, 7'h25, 7'h26, 7'h27};
    localparam logic [7:0] TM [15] = '{8'h04, 8'hE1, 8'h11, 8'h0F, 8'hFF, 8'h3F, 8'hFF,
        8'hFF, 8'h0F, 8'h2F, 8'h74, 8'h0F, 8'hFF, 8'h7F, 8'hFF};
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic ref_clk_pin = 1'b0;
    logic fb_clk_pin = 1'b0;
    logic cal_done_pin = 1'b0;
    logic [6:0] reg_addr, nvm_addr;
    logic [7:0] reg_wdata, reg_rdata, nvm_data, lf_cap_one, lf_cap_three;
    logic reg_wr, reg_rd, reg_rd_done, reg_busy, filter_sel, post_div_five, cal_start;
    logic first_clock_output_en, second_clock_output_en, ref_div_four, doubler_en;
    logic [1:0] mod_order, dither_sel, slew_sel;
    logic [3:0] cp_slices, lf_res_two;
    logic [6:0] lf_res_three;
    logic [2:0] phase_shift;
    logic [8:0] out_div, od, ex;
    logic [11:0] int_val;
    logic [21:0] num_val, fraction_denominator, nv, nprev;
    logic [7:0] m [0:127];
    logic [7:0] q [$];
    logic rd_pend = 1'b0;
    int mismatches = 0;
    int n_tests = 0;
    int n_cal = 0;
    int cycles = 0;

    always #20 sys_clk = ~sys_clk;

    pscr_host_model u_host (.sys_clk, .nvm_addr, .nvm_data, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rd_done);

    pscr_config_regs dut (.sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rd_done, .reg_rdata, .reg_busy, .nvm_addr, .nvm_data, .ref_clk_pin,
        .fb_clk_pin, .cal_done_pin, .mod_order, .cp_slices, .lf_res_two, .lf_cap_one,
        .lf_res_three, .lf_cap_three, .phase_shift, .filter_sel, .dither_sel,
        .post_div_five, .out_div, .slew_sel, .first_clock_output_en,
        .second_clock_output_en, .ref_div_four, .doubler_en, .int_val, .num_val,
        .fraction_denominator, .cal_start);

    task automatic stop_test();
        if (mismatches == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [21:0] e, input logic [21:0] g);
        n_tests++;
        if (g !== e)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic w(input logic [6:0] a, input logic [7:0] d);
        m[a] = d;
        u_host.wr(a, d);
    endtask : w

    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        q.push_back(e);
        u_host.rd(a);
    endtask : rd

    task automatic tick(input logic r, input logic f, input int n);
        repeat (n)
        begin
            @(negedge sys_clk);
            ref_clk_pin = r;
            fb_clk_pin = f;
            repeat (4) @(negedge sys_clk);
            ref_clk_pin = 1'b0;
            fb_clk_pin = 1'b0;
            repeat (4) @(negedge sys_clk);
        end
    endtask : tick

    // divider takes the held pair only when it lies in the legal range
    task automatic upd_ex();
        od = {m[ADDR_PDIV][BIT_ODIV_MSB], m[ADDR_ODIV_LO]};
        if (od >= ODIV_MIN && od <= ODIV_MAX)
            ex = od;
    endtask : upd_ex

    task automatic cfg_chk();
        @(negedge sys_clk);
        chk("mod_order", m[7'h21][1:0], mod_order);
        chk("dither_sel", m[7'h21][3:2], dither_sel);
        chk("cp_slices", m[7'h22][3:0], cp_slices);
        chk("doubler_en", m[7'h22][5], doubler_en);
        chk("phase_shift", m[7'h23][6:4], phase_shift);
        chk("filter_sel", m[7'h23][2], filter_sel);
        chk("lf_res_two", m[7'h24][3:0], lf_res_two);
        chk("lf_cap_one", m[7'h25], lf_cap_one);
        chk("lf_res_three", m[7'h26][6:0], lf_res_three);
        chk("lf_cap_three", m[7'h27], lf_cap_three);
        chk("post_div_five", m[7'h16][5], post_div_five);
        chk("slew_sel", m[7'h16][7:6], slew_sel);
        chk("first_clock_output_en", m[7'h14][2], first_clock_output_en);
        chk("second_clock_output_en", m[7'h18][4], second_clock_output_en);
        chk("ref_div_four", m[7'h18][0], ref_div_four);
        chk("int_val", {m[7'h19][3:0], m[7'h1A]}, int_val);
        chk("den", {m[7'h1E][5:0], m[7'h1F], m[7'h20]}, fraction_denominator);
        chk("num_val", {m[7'h1B][5:0], m[7'h1C], m[7'h1D]}, num_val);
        chk("cfg out_div", ex, out_div);
    endtask : cfg_chk

    // read data answers the cycle after the read strobe
    always @(posedge sys_clk)
    begin
        if (rd_pend && q.size() > 0)
            chk("reg_rdata", q.pop_front(), reg_rdata);
        rd_pend <= reg_rd;
        if (cal_start === 1'b1)
            n_cal++;
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            stop_test();
        end
    end

    initial
    begin
        void'($urandom(11382));
        repeat (20) @(negedge sys_clk);
        chk("reset first_clock_output_en", 1, first_clock_output_en);
        chk("reset second_clock_output_en", 0, second_clock_output_en);
        chk("reset out_div", ODIV_MIN, out_div);
        chk("reset busy", 1, reg_busy);
        chk("reset nvm_addr", 0, nvm_addr);
        resetn = 1'b1;
        repeat (100) @(negedge sys_clk);
        u_host.wr(ADDR_MOD, 8'h03);
        for (int i = 0; i < 300 && reg_busy !== 1'b0; i++)
            @(negedge sys_clk);
        for (int i = 0; i < 128; i++)
            m[i] = u_host.mem[i];
        chk("busy low", 0, reg_busy);
        ex = ODIV_MIN;
        upd_ex();
        repeat (3) @(negedge sys_clk);
        chk("boot cal", 1, n_cal);
        cfg_chk();
        for (int k = 0; k < 4; k++)
        begin
            for (int j = 0; j < 15; j++)
                m[TA[j]] = 8'($urandom) & TM[j];
            m[ADDR_MOD] = k[0] ? {4'h0, DITHER_WEAK, 2'h3} : 8'h00;
            m[ADDR_CP] = {2'b00, k[1], 1'b0, k[0] ? CP_FRAC : CP_INT};
            m[ADDR_PS] = {1'b0, k[0] ? 3'h2 : 3'h0, 1'b0, k[0] | k[1], 2'b00};
            if (k[1:0] == 2'b00)
                m[ADDR_LF_R3] = 8'h00;
            for (int j = 0; j < 15; j++)
                w(TA[j], m[TA[j]]);
            upd_ex();
            cfg_chk();
        end
        for (int j = 0; j < 5; j++)
        begin
            od = 9'($urandom);
            if (j < 4)
                od = j[1] ? (j[0] ? 9'h006 : 9'h005) : (j[0] ? 9'h100 : 9'h0FF);
            w(ADDR_ODIV_LO, od[7:0]);
            chk("out_div low only", ex, out_div);
            w(ADDR_PDIV, {m[ADDR_PDIV][7:1], od[8]});
            if (od >= ODIV_MIN && od <= ODIV_MAX)
                ex = od;
            @(negedge sys_clk);
            chk("out_div", ex, out_div);
        end
        for (int j = 0; j < 2; j++)
        begin
            nprev = {m[7'h1B][5:0], m[7'h1C], m[7'h1D]};
            nv = 22'($urandom);
            w(ADDR_NUM_HI, {2'b00, nv[21:16]});
            w(ADDR_NUM_MID, nv[15:8]);
            chk("num partial", nprev, num_val);
            w(ADDR_NUM_LO, nv[7:0]);
            @(negedge sys_clk);
            chk("num_val", nv, num_val);
        end
        w(ADDR_RECAL, 8'h02);
        repeat (3) @(negedge sys_clk);
        chk("recal pulses", 2, n_cal);
        w(ADDR_STATUS, 8'hFF);
        w(7'h15, 8'hFF);
        rd(ADDR_RECAL, 8'h00);
        rd(ADDR_STATUS, 8'h00);
        rd(7'h15, 8'h00);
        rd(7'h50, 8'h00);
        tick(1'b1, 1'b1, 4);
        rd(ADDR_STATUS, 8'h00);
        tick(1'b1, 1'b0, 2);
        cal_done_pin = 1'b1;
        repeat (4) @(negedge sys_clk);
        cal_done_pin = 1'b0;
        repeat (4) @(negedge sys_clk);
        rd(ADDR_STATUS, 8'h03);
        rd(ADDR_STATUS, 8'h03);
        u_host.done();
        repeat (2) @(negedge sys_clk);
        rd(ADDR_STATUS, 8'h00);
        repeat (3) @(negedge sys_clk);
        stop_test();
    end
endmodule : tb_top
